// *** irb_pkg.sv ***
package irb_pkg;

	// ----------------------------------------------------------------
	// Clock and bit timing
	// ----------------------------------------------------------------
	localparam int         CLK_HZ        = 20000000;
	localparam int         BAUD          = 9600;
	localparam int         TICKS_PER_BIT = 16;
	// Divider rounds down: the tick runs slightly fast (0.2 %)
	localparam logic [7:0] TICK_DIV      = 8'(CLK_HZ / (BAUD * TICKS_PER_BIT));
	localparam logic [3:0] LAST_TICK     = 4'hf;
	localparam logic [3:0] MID_TICK      = 4'h7;
	localparam logic [3:0] PULSE_FIRST   = 4'h7;
	localparam logic [3:0] PULSE_LAST    = 4'h9;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] IR_LAST_BIT   = 4'h8;

	// ----------------------------------------------------------------
	// Buffers
	// ----------------------------------------------------------------
	localparam int         HOST_BUF_DEPTH = 29;
	localparam int         HOST_CW        = 5;
	localparam logic [4:0] CTS_ON_LEVEL   = 5'h17;
	localparam int         IR_BUF_DEPTH   = 64;
	localparam int         IR_CW          = 7;

	// ----------------------------------------------------------------
	// Power and link
	// ----------------------------------------------------------------
	localparam int          IDLE_TIME_S     = 10;
	localparam int          IDLE_W          = 28;
	localparam logic [27:0] IDLE_CYCLES_DEF = 28'(IDLE_TIME_S * CLK_HZ);
	localparam logic [15:0] ADV_BAUD_CODE   = 16'h2580;

	// ----------------------------------------------------------------
	// Synchroniser bit positions
	// ----------------------------------------------------------------
	localparam int SYNC_W  = 8;
	localparam int S_HTX   = 0;
	localparam int S_RTS   = 1;
	localparam int S_CD    = 2;
	localparam int S_RI    = 3;
	localparam int S_DTR   = 4;
	localparam int S_IRIN  = 5;
	localparam int S_PDIN  = 6;
	localparam int S_PDREF = 7;

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		SER_IDLE  = 4'h1,
		SER_START = 4'h2,
		SER_DATA  = 4'h4,
		SER_STOP  = 4'h8
	} irb_ser_e;

	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'h1,
		PWR_LOW    = 2'h2
	} irb_pwr_e;

	function automatic logic bitEnd(input logic tick, input logic [3:0] tk);
		return tick && (tk == LAST_TICK);
	endfunction

	function automatic logic irPulse(input logic bitVal, input logic [3:0] tk);
		return !bitVal && (tk >= PULSE_FIRST) && (tk <= PULSE_LAST);
	endfunction

endpackage

// *** irb_fifo_if.sv ***
`timescale 1ns/1ps
interface irb_fifo_if #(
	parameter int WIDTH = 8,
	parameter int CW    = 5
);
	logic [WIDTH-1:0] inData;
	logic             inValid;
	logic             inReady;
	logic [WIDTH-1:0] outData;
	logic             outValid;
	logic             outReady;
	logic [CW-1:0]    count;

	modport store (
		input  inData,
		input  inValid,
		input  outReady,
		output inReady,
		output outData,
		output outValid,
		output count
	);

	modport user (
		output inData,
		output inValid,
		output outReady,
		input  inReady,
		input  outData,
		input  outValid,
		input  count
	);
endinterface

// *** irb_fifo.sv ***
`timescale 1ns/1ps
module irb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic   ref_clk,
	input wire logic   rst,
	irb_fifo_if.store  f
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [CW-1:0]               cnt;
	} irb_fifo_s;

	irb_fifo_s st;
	irb_fifo_s nxt;
	logic      push;
	logic      pop;

	assign f.inReady  = (st.cnt != CW'(DEPTH));
	assign f.outValid = (st.cnt != '0);
	assign f.outData  = st.mem[st.rp];
	assign f.count    = st.cnt;
	assign push       = f.inValid && f.inReady;
	assign pop        = f.outValid && f.outReady;

	// Depth need not be a power of two, so pointers wrap explicitly
	always_comb begin
		nxt = st;
		if (push) begin
			nxt.mem[st.wp] = f.inData;
			nxt.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + AW'(1);
		end
		if (pop) begin
			nxt.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + AW'(1);
		end
		if (push && !pop) begin
			nxt.cnt = st.cnt + CW'(1);
		end else if (pop && !push) begin
			nxt.cnt = st.cnt - CW'(1);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= nxt;
		end
	end
endmodule

// *** irb_codec.sv ***
// Function
// [R01] Sixteen derived ticks per serial bit
// [R02] Receive stop bit not tick timed
// [R03] Host serial port strictly half duplex
// [R04] Forward data, CD, RI, DTR; local handshakes
// [R05] Host port fixed at 9600 baud
// [R06] Host uses the same baud rate
// [R07] DSR shows infrared link established
// [R08] Deliver only while RTS low
// [R09] Buffers of 64 and 29 bytes
// [R10] CTS high means host must stop
// [R11] Six more bytes accepted after CTS
// [R12] Zero bit: pulse ticks seven to nine
// [R13] Zero bit decoded from early low
// [R14] Host output holds each bit fully
// [R15] IR port 9600, advertised when disconnected
// [R16] Ten idle seconds disconnected: low power
// [R17] Low power drives protocol-active low
// [R18] Photo-detect crossing wakes the device
// [R19] Reset exits low power too
// [R20] RTS high not ready, low ready
// [R21] Carrier detect passed with polarity
// [R22] CTS rises at 23 buffered bytes
// [R23] Held in reset, then runs
// [R24] Frame: start, eight LSB first, stop
// [R25] CTS falls once buffer empty
`timescale 1ns/1ps
module irb_codec #(
	parameter logic [27:0] IDLE_CYCLES = irb_pkg::IDLE_CYCLES_DEF
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        hostTxIn,
	output logic             hostRxOut,
	input  wire logic        hostReadyN,
	output logic             hostClearN,
	output logic             dataSetReady,
	input  wire logic        cdIn,
	input  wire logic        riIn,
	input  wire logic        dtrIn,
	output logic             cdToPrimary,
	output logic             riToPrimary,
	output logic             dtrToPrimary,
	input  wire logic        linkUp,
	output logic             hostStalled,
	output logic [7:0]       hostByteData,
	output logic             hostByteValid,
	input  wire logic        hostByteReady,
	input  wire logic [7:0]  stackToHostData,
	input  wire logic        stackToHostValid,
	output logic             stackToHostReady,
	input  wire logic [7:0]  irTxData,
	input  wire logic        irTxValid,
	output logic             irTxReady,
	output logic [7:0]       irRxData,
	output logic             irRxValid,
	output logic             irPulseOut,
	input  wire logic        irPulseIn,
	input  wire logic        photoDetectIn,
	input  wire logic        photoDetectRef,
	output logic             protocolActiveOut,
	output logic             protocolActiveOeN,
	output logic             oscEnable,
	output logic             advBaudValid,
	output logic [15:0]      advBaudCode
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [irb_pkg::SYNC_W-1:0] sync1;
		logic [irb_pkg::SYNC_W-1:0] sync2;
		logic                       irPrev;
		logic                       htxPrev;
		logic                       pdAbovePrev;
		logic [7:0]                 tickDiv;
		logic                       tick;
		irb_pkg::irb_ser_e          hrSt;
		logic [3:0]                 hrTk;
		logic [3:0]                 hrBit;
		logic [7:0]                 hrShift;
		logic                       hrPush;
		irb_pkg::irb_ser_e          htSt;
		logic [3:0]                 htTk;
		logic [3:0]                 htBit;
		logic [7:0]                 htShift;
		logic                       htLine;
		irb_pkg::irb_ser_e          irSt;
		logic [3:0]                 irTk;
		logic [3:0]                 irBit;
		logic [7:0]                 irShift;
		logic                       irLow;
		logic [7:0]                 irData;
		logic                       irValid;
		irb_pkg::irb_ser_e          itSt;
		logic [3:0]                 itTk;
		logic [3:0]                 itBit;
		logic [7:0]                 itShift;
		logic                       itLine;
		logic                       cts;
		logic                       dsr;
		logic                       stall;
		irb_pkg::irb_pwr_e          pwr;
		logic [irb_pkg::IDLE_W-1:0] idleCnt;
	} irb_top_s;

	irb_top_s st;
	irb_top_s nxt;

	logic hostLine;
	logic hostFall;
	logic irFall;
	logic irLowNow;
	logic rtsReady;
	logic pdAbove;
	logic active;
	logic hostTxStart;
	logic irTxStart;
	logic irBitVal;
	logic itBitVal;

	irb_fifo_if #(.WIDTH(8), .CW(irb_pkg::HOST_CW)) hostBuf ();
	irb_fifo_if #(.WIDTH(8), .CW(irb_pkg::IR_CW))   irBuf ();

	// ----------------------------------------------------------------
	// Buffers
	// ----------------------------------------------------------------
	// [R09] Host byte buffer
	irb_fifo #(.WIDTH(8), .DEPTH(irb_pkg::HOST_BUF_DEPTH)) uHostBuf (
		.ref_clk (ref_clk),
		.rst     (rst),
		.f       (hostBuf)
	);

	// [R09] Infrared data buffer
	irb_fifo #(.WIDTH(8), .DEPTH(irb_pkg::IR_BUF_DEPTH)) uIrBuf (
		.ref_clk (ref_clk),
		.rst     (rst),
		.f       (irBuf)
	);

	// Bytes past the 29th are dropped: host ignored CTS too long
	assign hostBuf.inData   = st.hrShift;
	assign hostBuf.inValid  = st.hrPush;
	assign hostBuf.outReady = hostByteReady;
	assign hostByteData     = hostBuf.outData;
	assign hostByteValid    = hostBuf.outValid;

	assign irBuf.inData     = stackToHostData;
	assign irBuf.inValid    = stackToHostValid;
	assign stackToHostReady = irBuf.inReady;
	assign irBuf.outReady   = hostTxStart;

	// ----------------------------------------------------------------
	// Decoded inputs
	// ----------------------------------------------------------------
	assign hostLine = st.sync2[irb_pkg::S_HTX];
	assign hostFall = st.htxPrev && !hostLine;
	assign irLowNow = !st.sync2[irb_pkg::S_IRIN];
	assign irFall   = st.irPrev && irLowNow;
	// [R20] RTS low is ready
	assign rtsReady = !st.sync2[irb_pkg::S_RTS];
	assign pdAbove  = st.sync2[irb_pkg::S_PDIN] && !st.sync2[irb_pkg::S_PDREF];
	assign active   = (st.pwr == irb_pkg::PWR_ACTIVE);

	// [R03] Half duplex start
	// [R08] Needs RTS low
	assign hostTxStart = (st.htSt == irb_pkg::SER_IDLE)
		&& (st.hrSt == irb_pkg::SER_IDLE) && !hostFall
		&& irBuf.outValid && rtsReady;
	assign irTxReady   = (st.itSt == irb_pkg::SER_IDLE) && active;
	assign irTxStart   = irTxValid && irTxReady;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt = st;
		irBitVal = 1'b1;
		itBitVal = 1'b1;
		nxt.sync1 = {photoDetectRef, photoDetectIn, irPulseIn, dtrIn,
			riIn, cdIn, hostReadyN, hostTxIn};
		nxt.sync2 = st.sync1;
		nxt.irPrev = st.sync2[irb_pkg::S_IRIN];
		nxt.htxPrev = hostLine;
		nxt.pdAbovePrev = pdAbove;
		// [R04] Locally made handshakes
		nxt.dsr = linkUp;
		nxt.stall = irBuf.outValid && !rtsReady;

		// [R01] Tick divider
		// [R05] Fixed rate
		nxt.tick = 1'b0;
		if (st.tickDiv == irb_pkg::TICK_DIV - 8'h01) begin
			nxt.tickDiv = '0;
			nxt.tick = 1'b1;
		end else begin
			nxt.tickDiv = st.tickDiv + 8'h01;
		end

		// [R24] Host receive framing
		nxt.hrPush = 1'b0;
		case (st.hrSt)
			irb_pkg::SER_IDLE: begin
				if (hostFall && (st.htSt == irb_pkg::SER_IDLE)) begin
					nxt.hrSt = irb_pkg::SER_START;
					nxt.hrTk = '0;
				end
			end
			irb_pkg::SER_START: begin
				if (st.tick) begin
					nxt.hrTk = st.hrTk + 4'h1;
					if (st.hrTk == irb_pkg::MID_TICK) begin
						nxt.hrTk = '0;
						nxt.hrBit = '0;
						nxt.hrSt = hostLine ? irb_pkg::SER_IDLE
							: irb_pkg::SER_DATA;
					end
				end
			end
			irb_pkg::SER_DATA: begin
				if (st.tick) begin
					nxt.hrTk = st.hrTk + 4'h1;
				end
				if (irb_pkg::bitEnd(st.tick, st.hrTk)) begin
					nxt.hrShift = {hostLine, st.hrShift[7:1]};
					nxt.hrBit = st.hrBit + 4'h1;
					if (st.hrBit == irb_pkg::LAST_DATA_BIT) begin
						nxt.hrPush = 1'b1;
						nxt.hrSt = irb_pkg::SER_STOP;
					end
				end
			end
			// [R02] Stop awaited untimed
			irb_pkg::SER_STOP: begin
				if (hostLine) begin
					nxt.hrSt = irb_pkg::SER_IDLE;
				end
			end
			default: begin
				nxt.hrSt = irb_pkg::SER_IDLE;
			end
		endcase

		// [R10] CTS hysteresis
		// [R22] Raise at 23
		// [R11] Room for six more
		// [R25] Drop when emptied
		if (hostBuf.count >= irb_pkg::CTS_ON_LEVEL) begin
			nxt.cts = 1'b1;
		end else if (hostBuf.count == '0) begin
			nxt.cts = 1'b0;
		end

		// [R14] Host transmit, full bits
		case (st.htSt)
			irb_pkg::SER_IDLE: begin
				nxt.htLine = 1'b1;
				if (hostTxStart) begin
					nxt.htSt = irb_pkg::SER_START;
					nxt.htTk = '0;
					nxt.htShift = irBuf.outData;
					nxt.htLine = 1'b0;
				end
			end
			irb_pkg::SER_START: begin
				if (st.tick) begin
					nxt.htTk = st.htTk + 4'h1;
				end
				if (irb_pkg::bitEnd(st.tick, st.htTk)) begin
					nxt.htSt = irb_pkg::SER_DATA;
					nxt.htBit = '0;
					nxt.htLine = st.htShift[0];
				end
			end
			irb_pkg::SER_DATA: begin
				if (st.tick) begin
					nxt.htTk = st.htTk + 4'h1;
				end
				if (irb_pkg::bitEnd(st.tick, st.htTk)) begin
					nxt.htShift = {1'b1, st.htShift[7:1]};
					nxt.htBit = st.htBit + 4'h1;
					nxt.htLine = st.htShift[1];
					if (st.htBit == irb_pkg::LAST_DATA_BIT) begin
						nxt.htSt = irb_pkg::SER_STOP;
						nxt.htLine = 1'b1;
					end
				end
			end
			irb_pkg::SER_STOP: begin
				if (st.tick) begin
					nxt.htTk = st.htTk + 4'h1;
				end
				if (irb_pkg::bitEnd(st.tick, st.htTk)) begin
					nxt.htSt = irb_pkg::SER_IDLE;
				end
			end
			default: begin
				nxt.htSt = irb_pkg::SER_IDLE;
				nxt.htLine = 1'b1;
			end
		endcase

		// [R13] Infrared decode
		// Only the first half window counts: jitter may not leak
		case (st.irSt)
			irb_pkg::SER_IDLE: begin
				nxt.irValid = 1'b0;
				if (active && irFall) begin
					nxt.irSt = irb_pkg::SER_DATA;
					nxt.irTk = '0;
					nxt.irBit = '0;
					nxt.irLow = 1'b1;
				end
			end
			irb_pkg::SER_DATA: begin
				if (!st.irTk[3]) begin
					nxt.irLow = st.irLow || irLowNow;
				end
				if (st.tick) begin
					nxt.irTk = st.irTk + 4'h1;
				end
				if (irb_pkg::bitEnd(st.tick, st.irTk)) begin
					irBitVal = !st.irLow;
					nxt.irLow = irLowNow;
					nxt.irBit = st.irBit + 4'h1;
					if (st.irBit == '0) begin
						if (irBitVal) begin
							nxt.irSt = irb_pkg::SER_IDLE;
						end
					end else begin
						nxt.irShift = {irBitVal, st.irShift[7:1]};
						// [R02] No timed stop
						if (st.irBit == irb_pkg::IR_LAST_BIT) begin
							nxt.irData = {irBitVal, st.irShift[7:1]};
							nxt.irValid = 1'b1;
							nxt.irSt = irb_pkg::SER_IDLE;
						end
					end
				end
			end
			default: begin
				nxt.irSt = irb_pkg::SER_IDLE;
			end
		endcase
		if (!active) begin
			nxt.irSt = irb_pkg::SER_IDLE;
		end

		// [R15] Infrared transmit framing
		case (st.itSt)
			irb_pkg::SER_IDLE: begin
				if (irTxStart) begin
					nxt.itSt = irb_pkg::SER_START;
					nxt.itTk = '0;
					nxt.itShift = irTxData;
				end
			end
			irb_pkg::SER_START: begin
				if (st.tick) begin
					nxt.itTk = st.itTk + 4'h1;
				end
				if (irb_pkg::bitEnd(st.tick, st.itTk)) begin
					nxt.itSt = irb_pkg::SER_DATA;
					nxt.itBit = '0;
				end
			end
			irb_pkg::SER_DATA: begin
				if (st.tick) begin
					nxt.itTk = st.itTk + 4'h1;
				end
				if (irb_pkg::bitEnd(st.tick, st.itTk)) begin
					nxt.itShift = {1'b1, st.itShift[7:1]};
					nxt.itBit = st.itBit + 4'h1;
					if (st.itBit == irb_pkg::LAST_DATA_BIT) begin
						nxt.itSt = irb_pkg::SER_STOP;
					end
				end
			end
			irb_pkg::SER_STOP: begin
				if (st.tick) begin
					nxt.itTk = st.itTk + 4'h1;
				end
				if (irb_pkg::bitEnd(st.tick, st.itTk)) begin
					nxt.itSt = irb_pkg::SER_IDLE;
				end
			end
			default: begin
				nxt.itSt = irb_pkg::SER_IDLE;
			end
		endcase
		if (!active) begin
			nxt.itSt = irb_pkg::SER_IDLE;
		end
		case (nxt.itSt)
			irb_pkg::SER_START: itBitVal = 1'b0;
			irb_pkg::SER_DATA:  itBitVal = nxt.itShift[0];
			default:            itBitVal = 1'b1;
		endcase
		// [R12] Zero bit pulse
		nxt.itLine = (nxt.itSt != irb_pkg::SER_IDLE)
			&& irb_pkg::irPulse(itBitVal, nxt.itTk);

		// [R16] Idle timeout
		// [R18] Crossing wakes
		case (st.pwr)
			irb_pkg::PWR_ACTIVE: begin
				if (irFall || linkUp) begin
					nxt.idleCnt = '0;
				end else if (st.idleCnt == IDLE_CYCLES - 28'h000_0001) begin
					nxt.idleCnt = '0;
					nxt.pwr = irb_pkg::PWR_LOW;
				end else begin
					nxt.idleCnt = st.idleCnt + 28'h000_0001;
				end
			end
			irb_pkg::PWR_LOW: begin
				nxt.idleCnt = '0;
				if (pdAbove && !st.pdAbovePrev) begin
					nxt.pwr = irb_pkg::PWR_ACTIVE;
				end
			end
			default: begin
				nxt.pwr = irb_pkg::PWR_ACTIVE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// [R23] Reset hold
	// [R19] Reset wakes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.hrSt <= irb_pkg::SER_IDLE;
			st.htSt <= irb_pkg::SER_IDLE;
			st.irSt <= irb_pkg::SER_IDLE;
			st.itSt <= irb_pkg::SER_IDLE;
			st.htLine <= 1'b1;
			st.pwr <= irb_pkg::PWR_ACTIVE;
		end else begin
			st <= nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hostRxOut    = st.htLine;
	assign hostClearN   = st.cts;
	// [R07] Link status
	assign dataSetReady = st.dsr;
	// [R21] CD polarity kept
	assign cdToPrimary  = st.sync2[irb_pkg::S_CD];
	assign riToPrimary  = st.sync2[irb_pkg::S_RI];
	assign dtrToPrimary = st.sync2[irb_pkg::S_DTR];
	assign hostStalled  = st.stall;
	assign irRxData     = st.irData;
	assign irRxValid    = st.irValid;
	assign irPulseOut   = st.itLine;
	// [R17] Open collector, low in sleep
	assign protocolActiveOut = 1'b0;
	assign protocolActiveOeN = active;
	assign oscEnable    = active;
	// [R15] Advertise rate when disconnected
	assign advBaudValid = !st.dsr;
	assign advBaudCode  = irb_pkg::ADV_BAUD_CODE;
endmodule

// *** irb_codec_chk.sv ***
`timescale 1ns/1ps
module irb_codec_chk (
	input logic        ref_clk,
	input logic        rst,
	input logic        linkUp,
	input logic        dataSetReady,
	input logic        advBaudValid,
	input logic [15:0] advBaudCode,
	input logic        oscEnable,
	input logic        protocolActiveOeN,
	input logic        protocolActiveOut,
	input logic        irTxReady,
	input logic        irPulseOut,
	input logic        irRxValid,
	input logic        hostByteValid,
	input logic        hostClearN,
	input logic        cdIn,
	input logic        cdToPrimary,
	input logic        photoDetectIn,
	input logic        photoDetectRef
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ----------------
	// Pulse length
	// ----------------
	logic [9:0] hiLen_ff;
	logic [9:0] nxt_hiLen;

	always_comb nxt_hiLen = irPulseOut ? hiLen_ff + 10'h001 : 10'h000;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) hiLen_ff <= 10'h000;
		else hiLen_ff <= nxt_hiLen;
	end

	a_dsr_link_state: assert property (
		$changed(linkUp) |=> dataSetReady == $past(linkUp))
		else $error("link indication wrong");
	a_adv_baud_code: assert property (
		advBaudValid == !dataSetReady && advBaudCode == 16'h2580)
		else $error("advertised rate wrong");
	a_power_pin_osc: assert property (
		oscEnable == protocolActiveOeN && protocolActiveOut == 1'b0)
		else $error("activity pin disagrees with power");
	a_low_power_tx: assert property (
		!oscEnable |-> !irTxReady)
		else $error("encoder ready in low power");
	// Abort on sleep may cut a pulse short
	a_ir_pulse_len: assert property (
		@(posedge ref_clk) disable iff (rst || !oscEnable)
		$fell(irPulseOut) |-> hiLen_ff == 10'h186)
		else $error("pulse not three ticks");
	a_rx_valid_pulse: assert property (
		irRxValid |=> !irRxValid)
		else $error("decoded byte strobe too long");
	a_cts_drop_empty: assert property (
		!hostByteValid |=> !hostClearN)
		else $error("flow stop held on empty buffer");
	a_carrier_fwd: assert property (
		$rose(cdIn) ##1 cdIn[*4] |=> cdToPrimary)
		else $error("carrier state not forwarded");
	a_wake_on_light: assert property (
		!oscEnable && $rose(photoDetectIn) && !photoDetectRef
		##1 (photoDetectIn && !photoDetectRef)[*5] |=> oscEnable)
		else $error("no wake on light");
endmodule

bind irb_codec irb_codec_chk chk (
	.ref_clk, .rst, .linkUp, .dataSetReady, .advBaudValid, .advBaudCode,
	.oscEnable, .protocolActiveOeN, .protocolActiveOut, .irTxReady,
	.irPulseOut, .irRxValid, .hostByteValid, .hostClearN, .cdIn,
	.cdToPrimary, .photoDetectIn, .photoDetectRef
);

// *** irb_host_uart.sv ***
`timescale 1ns/1ps
// --------------------------
// Host controller UART model
// --------------------------
module irb_host_uart (
	input  logic       ref_clk,
	input  logic       hostRxOut,
	input  logic       hostClearN,
	output logic       hostTxIn,
	output logic [7:0] rxByte,
	output logic       rxDone
);
	localparam int BIT = irb_pkg::TICKS_PER_BIT * int'(irb_pkg::TICK_DIV);

	initial begin
		hostTxIn = 1'b1;
		rxByte = 8'h00;
		rxDone = 1'b0;
	end

	task automatic send(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		while (hostClearN !== 1'b0) @(negedge ref_clk);
		for (int i = 0; i < 10; i++) begin
			hostTxIn = fr[i];
			repeat (BIT) @(negedge ref_clk);
		end
	endtask

	// Mid-bit sampling tolerates the free-running tick phase
	always begin
		@(negedge hostRxOut);
		rxDone = 1'b0;
		repeat (BIT / 2) @(negedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(negedge ref_clk);
			rxByte[i] = hostRxOut;
		end
		repeat (BIT) @(negedge ref_clk);
		rxDone = 1'b1;
	end
endmodule

// *** irb_codec_tb.sv ***
`timescale 1ns/1ps
module irb_codec_tb;
	localparam int TD  = int'(irb_pkg::TICK_DIV);
	localparam int BIT = irb_pkg::TICKS_PER_BIT * TD;

	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        hostReadyN = 1'b0;
	logic        cdIn = 1'b0, riIn = 1'b0, dtrIn = 1'b0, linkUp = 1'b0;
	logic        hostByteReady = 1'b0, stackToHostValid = 1'b0;
	logic [7:0]  stackToHostData = 8'h00, irTxData = 8'h00;
	logic        irTxValid = 1'b0, irPulseIn = 1'b1;
	logic        photoDetectIn = 1'b0, photoDetectRef = 1'b0;
	logic        hostTxIn, hostRxOut, hostClearN, dataSetReady, rxDone;
	logic        cdToPrimary, riToPrimary, dtrToPrimary, hostStalled;
	logic        hostByteValid, stackToHostReady, irTxReady, irRxValid;
	logic        irPulseOut, protocolActiveOut, protocolActiveOeN;
	logic        oscEnable, advBaudValid;
	logic [7:0]  hostByteData, irRxData, rxByte;
	logic [15:0] advBaudCode;
	int          n_fail = 0;
	int          comparisons = 0;

	always #25 ref_clk = ~ref_clk;

	irb_codec #(.IDLE_CYCLES(28'h000_1388)) dut (
		.ref_clk, .rst, .hostTxIn, .hostRxOut, .hostReadyN, .hostClearN,
		.dataSetReady, .cdIn, .riIn, .dtrIn, .cdToPrimary, .riToPrimary,
		.dtrToPrimary, .linkUp, .hostStalled, .hostByteData, .hostByteValid,
		.hostByteReady, .stackToHostData, .stackToHostValid,
		.stackToHostReady, .irTxData, .irTxValid, .irTxReady, .irRxData,
		.irRxValid, .irPulseOut, .irPulseIn, .photoDetectIn, .photoDetectRef,
		.protocolActiveOut, .protocolActiveOeN, .oscEnable, .advBaudValid,
		.advBaudCode
	);

	irb_host_uart host (
		.ref_clk, .hostRxOut, .hostClearN, .hostTxIn, .rxByte, .rxDone
	);

	// ----------------
	// Helpers
	// ----------------
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wait_hi(ref logic s, input int lim);
		for (int i = 0; i < lim && s !== 1'b1; i++) @(negedge ref_clk);
		check({15'h0000, s}, 16'h0001);
	endtask

	task automatic ir_send(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			irPulseIn = fr[i];
			repeat (3 * TD) @(negedge ref_clk);
			irPulseIn = 1'b1;
			repeat (13 * TD) @(negedge ref_clk);
		end
	endtask

	// ----------------
	// Scenarios
	// ----------------
	task automatic t_reset;
		logic [15:0] v;
		v = {5'h00, hostRxOut, hostClearN, dataSetReady, irPulseOut,
			irRxValid, hostByteValid, stackToHostReady, irTxReady,
			protocolActiveOeN, oscEnable, advBaudValid};
		check(v, 16'h041f);
		check(advBaudCode, 16'h2580);
	endtask

	task automatic t_side;
		{linkUp, cdIn, riIn, dtrIn} = 4'hf;
		repeat (6) @(negedge ref_clk);
		check({11'h000, dataSetReady, cdToPrimary, riToPrimary,
			dtrToPrimary, advBaudValid}, 16'h001e);
		{cdIn, riIn, dtrIn} = 3'h0;
		repeat (6) @(negedge ref_clk);
		check({13'h0000, cdToPrimary, riToPrimary, dtrToPrimary}, 16'h0000);
	endtask

	task automatic t_ir_tx;
		int   r[$];
		logic p;
		p = 1'b0;
		irTxData = 8'h5a;
		irTxValid = 1'b1;
		while (!irTxReady) @(negedge ref_clk);
		@(negedge ref_clk);
		irTxValid = 1'b0;
		for (int i = 0; i < 11 * BIT; i++) begin
			if (irPulseOut && !p) r.push_back(i);
			p = irPulseOut;
			@(negedge ref_clk);
		end
		check(16'(r.size()), 16'h0005);
		check(16'(r[1] - r[0]), 16'(BIT));
		check(16'(r[2] - r[1]), 16'(2 * BIT));
	endtask

	task automatic t_host_rx;
		host.send(8'hc3);
		wait_hi(hostByteValid, BIT);
		check({8'h00, hostByteData}, 16'h00c3);
		check({15'h0000, hostClearN}, 16'h0000);
		hostByteReady = 1'b1;
		@(negedge ref_clk);
		hostByteReady = 1'b0;
		@(negedge ref_clk);
		check({15'h0000, hostByteValid}, 16'h0000);
	endtask

	task automatic t_ir_rx_host_tx;
		logic [7:0] got;
		got = 8'h00;
		hostReadyN = 1'b1;
		// RTS passes a two-stage synchroniser: let it settle before data
		repeat (3) @(negedge ref_clk);
		stackToHostData = 8'h3e;
		stackToHostValid = 1'b1;
		while (!stackToHostReady) @(negedge ref_clk);
		@(negedge ref_clk);
		stackToHostValid = 1'b0;
		repeat (8) @(negedge ref_clk);
		check({14'h0000, hostStalled, hostRxOut}, 16'h0003);
		fork
			ir_send(8'h96);
			begin
				wait_hi(irRxValid, 12 * BIT);
				got = irRxData;
			end
			begin
				hostReadyN = 1'b0;
				wait_hi(rxDone, 12 * BIT);
			end
		join
		check({8'h00, got}, 16'h0096);
		check({8'h00, rxByte}, 16'h003e);
	endtask

	task automatic t_power;
		linkUp = 1'b0;
		repeat (5100) @(negedge ref_clk);
		check({13'h0000, oscEnable, protocolActiveOeN, irTxReady}, 16'h0000);
		photoDetectIn = 1'b1;
		repeat (8) @(negedge ref_clk);
		check({14'h0000, oscEnable, protocolActiveOeN}, 16'h0003);
		photoDetectIn = 1'b0;
		repeat (5100) @(negedge ref_clk);
		check({15'h0000, protocolActiveOeN}, 16'h0000);
		rst = 1'b1;
		@(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		check({15'h0000, oscEnable}, 16'h0001);
	endtask

	initial begin
		repeat (3) @(negedge ref_clk);
		rst = 1'b0;
		t_reset();
		t_side();
		t_ir_tx();
		t_host_rx();
		t_ir_rx_host_tx();
		t_power();
		finish_test();
	end

	// Whole sequence needs about 75000 cycles
	initial begin
		repeat (95000) @(posedge ref_clk);
		n_fail++;
		finish_test();
	end
endmodule
